// [core/tmr_pkg.sv]
/*
  Shared constants for the timer: register map, field positions,
  reset values and mode encodings.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package tmr_pkg;
  localparam int CNT_W = 16;
  localparam int DT_W  = 8;
  localparam int NCH   = 4;
  localparam int NEV   = 5;
  localparam int AW    = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PSC    = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_COUNT  = 8'h0C;
  localparam logic [7:0] OFF_CHMODE = 8'h10;
  localparam logic [7:0] OFF_CMP0   = 8'h14;
  localparam logic [7:0] OFF_DT     = 8'h24;
  localparam logic [7:0] OFF_STAT   = 8'h28;
  localparam logic [7:0] OFF_CLR    = 8'h2C;
  localparam logic [7:0] OFF_IEN    = 8'h30;
  localparam logic [7:0] OFF_DEN    = 8'h34;
  // Control fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_DIR  = 1;
  localparam int CTRL_OPM  = 3;
  localparam int CTRL_FRZ  = 4;
  localparam int CTRL_DOFF = 5;
  localparam int CTRL_SRC  = 6;
  localparam int CTRL_HALL = 8;
  localparam int CTRL_SRST = 9;
  localparam int CTRL_W    = 10;
  // Per-channel mode nibble: [1:0] mode, [2] polarity, [3] output enable
  localparam int CHM_POL   = 2;
  localparam int CHM_OE    = 3;
  localparam int DT_EN     = 8;
  localparam int ST_UPD    = 0;
  // Reset values
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;
  typedef enum logic [1:0] {CNT_UP = 2'h0, CNT_DOWN = 2'h1, CNT_CENTER = 2'h2} cnt_mode_type;
  typedef enum logic [1:0] {SRC_CLK = 2'h0, SRC_ENC = 2'h1, SRC_TRIG = 2'h2} src_type;
  typedef enum logic [1:0] {CH_CMP = 2'h0, CH_CAP = 2'h1, CH_PWM = 2'h2} ch_mode_type;
endpackage

// [core/chan_if.sv]
/*
  Bundle between the timer core and one channel.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface chan_if;
  logic [15:0] cnt;
  logic [15:0] cmp;
  logic [1:0]  mode;
  logic        step;
  logic        cap_evt;
  logic        ref_lvl;
  logic        evt;
  modport core (output cnt, cmp, mode, step, cap_evt, input ref_lvl, evt);
  modport chan (input cnt, cmp, mode, step, cap_evt, output ref_lvl, evt);
endinterface

// [core/timer_channel.sv]
/*
  One capture/compare channel: compare toggle, PWM level, capture event.
  Assumes step pulses once per counter change.
*/
`timescale 1ns/10ps
module timer_channel (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core side
  chan_if.chan     bus
);
  logic ref_q;
  logic evt_q;
  logic hit;

  assign hit = bus.step && (bus.cnt == bus.cmp);
  assign bus.ref_lvl = ref_q;
  assign bus.evt = evt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_q <= 1'b0;
    end else begin
      case (bus.mode)
        tmr_pkg::CH_CMP: if (hit) ref_q <= ~ref_q;
        // Below compare is active: 0 is off, above period is on
        tmr_pkg::CH_PWM: ref_q <= (bus.cnt < bus.cmp);
        default:         ref_q <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= (bus.mode == tmr_pkg::CH_CAP) ? bus.cap_evt : hit;
    end
  end
endmodule

// [core/dead_time.sv]
/*
  Complementary output pair with dead time between edges.
  Assumes the reference level and settings are on the same clock.
*/
`timescale 1ns/10ps
module dead_time #(
  parameter int DT_W = 8
) (
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // Control
  input  wire logic            ref_lvl,
  input  wire logic            off,
  input  wire logic            comp_en,
  input  wire logic [DT_W-1:0] dt,
  // Pair
  output logic                 hi,
  output logic                 lo
);
  typedef enum logic [2:0] {
    S_DEAD = 3'h1, S_HI = 3'h2, S_LO = 3'h4
  } dt_state_type;
  dt_state_type    st_q;
  logic [DT_W-1:0] cnt_q;
  logic [DT_W-1:0] lim;

  assign lim = comp_en ? dt : '0;

  // Both sides pass through the dead state, so never on together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= S_DEAD;
      hi    <= 1'b0;
      lo    <= 1'b0;
      cnt_q <= '0;
    end else begin
      case (st_q)
        S_HI: if (off || !ref_lvl) begin
          hi    <= 1'b0;
          cnt_q <= '0;
          st_q  <= S_DEAD;
        end
        S_LO: if (off || ref_lvl || !comp_en) begin
          lo    <= 1'b0;
          cnt_q <= '0;
          st_q  <= S_DEAD;
        end
        S_DEAD: if (off) begin
          cnt_q <= '0;
        end else if (cnt_q >= lim) begin
          if (ref_lvl) begin
            hi   <= 1'b1;
            st_q <= S_HI;
          end else if (comp_en) begin
            lo   <= 1'b1;
            st_q <= S_LO;
          end
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
        default: begin
          st_q <= S_DEAD;
          hi   <= 1'b0;
          lo   <= 1'b0;
        end
      endcase
    end
  end
endmodule

// [core/pwm_timer.sv]
/*
  Four-channel capture/compare/PWM timer with prescaler, auto-reload
  counter, encoder and hall inputs, dead-time pairs and AXI4-Lite slave.
  Assumes pins are asynchronous; trig_in and dbg_halt share aclk.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
// Overview of operation
// - 16-bit counter reloads from period; counts up, down or up/down.
// - Prescaler divides counting events by any ratio from 1 to 65536.
// - Four channels: capture, compare, PWM or one-pulse.
// - PWM edge-aligned in up and down modes, center-aligned in up/down mode.
// - Three complementary pairs on six outputs with programmable dead time.
// - PWM duty reaches fully off and fully on.
// - Debug halt can freeze counter and force outputs inactive.
// - Counter can hold its value while debug halt is high.
// - Trigger link: reset on input trigger, chain input as clock, output update.
// - Own DMA requests from update and channel events.
// - Quadrature encoder counts up or down by phase order.
// - Up to three hall inputs capture counter into channel 0 on change.
`timescale 1ns/10ps
module pwm_timer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Pins
  input  wire logic [3:0]  cap_in,
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic [2:0]  hall_in,
  output logic [3:0]       ch_out,
  output logic [2:0]       ch_out_n,
  // System
  input  wire logic        dbg_halt,
  input  wire logic        trig_in,
  output logic             trig_out,
  output logic [4:0]       dma_req,
  output logic             irq
);
  localparam int W = tmr_pkg::CNT_W;

  logic [8:0]   pin_s1, pin_s2, pin_s3;
  logic         trig_prev_q;
  logic [9:0]   ctrl_q;
  logic [W-1:0] psc_q, psc_cnt_q, per_q, cnt_q, cnt_d;
  logic [15:0]  chm_q;
  logic [W-1:0] cmp_q [tmr_pkg::NCH];
  logic [8:0]   dt_q;
  logic [4:0]   stat_q, ien_q, den_q, ev_set;
  logic         dir_q, dir_d, upd;
  logic         run, src_ev, tick, dn, trig_rise, enc_step, enc_dn, hall_chg;
  logic [3:0]   cap_rise, ch_evt, ch_ref, ch_pol;
  logic [2:0]   dt_hi, dt_lo;
  logic         ch3_q, outs_off;
  logic [7:0]   waddr_q;
  logic [31:0]  wdat_q;
  logic [3:0]   wstb_q;
  logic         aw_full_q, w_full_q, do_wr, wr_ok;
  logic [31:0]  rd_mux, wmask;
  logic         rd_ok;
  logic [1:0]   cmode;

  // Pin synchronisers; stage 3 is the previous value for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 9'h000;
      pin_s2 <= 9'h000;
      pin_s3 <= 9'h000;
      trig_prev_q <= 1'b0;
    end else begin
      pin_s1 <= {hall_in, enc_b, enc_a, cap_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      trig_prev_q <= trig_in;
    end
  end

  assign cap_rise  = pin_s2[3:0] & ~pin_s3[3:0];
  assign enc_step  = (pin_s2[4] ^ pin_s3[4]) ^ (pin_s2[5] ^ pin_s3[5]);
  assign enc_dn    = ~(pin_s2[4] ^ pin_s3[5]);
  assign hall_chg  = |(pin_s2[8:6] ^ pin_s3[8:6]);
  assign trig_rise = trig_in & ~trig_prev_q;

  // Counting event source and prescaler
  assign cmode = ctrl_q[tmr_pkg::CTRL_DIR +: 2];
  assign run   = ctrl_q[tmr_pkg::CTRL_EN] && !(ctrl_q[tmr_pkg::CTRL_FRZ] && dbg_halt);
  always_comb begin
    case (ctrl_q[tmr_pkg::CTRL_SRC +: 2])
      tmr_pkg::SRC_ENC:  src_ev = enc_step;
      tmr_pkg::SRC_TRIG: src_ev = trig_rise;
      default:           src_ev = 1'b1;
    endcase
  end
  // A count left above a newly lowered prescale value ends at once
  assign tick = run && src_ev && (psc_cnt_q >= psc_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_cnt_q <= '0;
    end else if (ctrl_q[tmr_pkg::CTRL_SRST] && trig_rise) begin
      psc_cnt_q <= '0;
    end else if (run && src_ev) begin
      psc_cnt_q <= (psc_cnt_q >= psc_q) ? '0 : psc_cnt_q + 1'b1;
    end
  end

  // Counter next value and update event
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    upd   = 1'b0;
    if (ctrl_q[tmr_pkg::CTRL_SRC +: 2] == tmr_pkg::SRC_ENC) dn = enc_dn;
    else if (cmode == tmr_pkg::CNT_DOWN) dn = 1'b1;
    else if (cmode == tmr_pkg::CNT_CENTER) dn = dir_q;
    else dn = 1'b0;
    if (tick) begin
      if (!dn && cnt_q >= per_q) begin
        upd = 1'b1;
        if (cmode == tmr_pkg::CNT_CENTER) begin
          dir_d = 1'b1;
          cnt_d = (per_q == '0) ? '0 : per_q - 1'b1;
        end else begin
          cnt_d = '0;
        end
      end else if (dn && cnt_q == '0) begin
        upd = 1'b1;
        if (cmode == tmr_pkg::CNT_CENTER) begin
          dir_d = 1'b0;
          cnt_d = (per_q == '0) ? '0 : 16'h0001;
        end else begin
          cnt_d = per_q;
        end
      end else begin
        cnt_d = dn ? cnt_q - 1'b1 : cnt_q + 1'b1;
      end
    end
    if (ctrl_q[tmr_pkg::CTRL_SRST] && trig_rise) begin
      cnt_d = '0;
      dir_d = 1'b0;
    end
    if (do_wr && waddr_q == tmr_pkg::OFF_COUNT) begin
      cnt_d = (cnt_q & ~wmask[15:0]) | (wdat_q[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      dir_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  // Channels
  generate
    for (genvar i = 0; i < tmr_pkg::NCH; i++) begin : g_ch
      chan_if cif ();
      assign cif.cnt     = cnt_q;
      assign cif.cmp     = cmp_q[i];
      assign cif.mode    = chm_q[4*i +: 2];
      assign cif.step    = tick;
      assign cif.cap_evt = (i == 0 && ctrl_q[tmr_pkg::CTRL_HALL]) ? hall_chg : cap_rise[i];
      assign ch_ref[i]   = cif.ref_lvl;
      assign ch_evt[i]   = cif.evt;
      assign ch_pol[i]   = chm_q[4*i + tmr_pkg::CHM_POL];
      timer_channel u_ch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .bus     (cif.chan)
      );

      // Compare value from software, or captured counter
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cmp_q[i] <= '0;
        end else if (cif.mode == tmr_pkg::CH_CAP && cif.cap_evt) begin
          cmp_q[i] <= cnt_q;
        end else if (do_wr && waddr_q == tmr_pkg::OFF_CMP0 + 8'(4 * i)) begin
          cmp_q[i] <= (cmp_q[i] & ~wmask[15:0]) | (wdat_q[15:0] & wmask[15:0]);
        end
      end

      if (i < 3) begin : g_pair
        dead_time #(.DT_W(tmr_pkg::DT_W)) u_dt (
          .aclk    (aclk),
          .aresetn (aresetn),
          .ref_lvl (ch_ref[i] ^ ch_pol[i]),
          .off     (outs_off || !chm_q[4*i + tmr_pkg::CHM_OE]),
          .comp_en (dt_q[tmr_pkg::DT_EN]),
          .dt      (dt_q[7:0]),
          .hi      (dt_hi[i]),
          .lo      (dt_lo[i])
        );
      end
    end
  endgenerate

  assign outs_off = ctrl_q[tmr_pkg::CTRL_DOFF] && dbg_halt;
  assign ch_out   = {ch3_q, dt_hi};
  assign ch_out_n = dt_lo;

  always_ff @(posedge aclk) begin
    if (!aresetn) ch3_q <= 1'b0;
    else ch3_q <= (ch_ref[3] ^ ch_pol[3]) && chm_q[4*3 + tmr_pkg::CHM_OE] && !outs_off;
  end

  // Events: status, interrupt, DMA and trigger out
  assign ev_set = {ch_evt, upd};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else if (do_wr && waddr_q == tmr_pkg::OFF_CLR) begin
      stat_q <= (stat_q & ~wdat_q[4:0]) | ev_set;
    end else begin
      stat_q <= stat_q | ev_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq      <= 1'b0;
      dma_req  <= '0;
      trig_out <= 1'b0;
    end else begin
      irq      <= |(stat_q & ien_q);
      dma_req  <= ev_set & den_q;
      trig_out <= upd;
    end
  end

  // Control registers; one-pulse clears enable on update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
    end else if (do_wr && waddr_q == tmr_pkg::OFF_CTRL) begin
      ctrl_q <= (ctrl_q & ~wmask[9:0]) | (wdat_q[9:0] & wmask[9:0]);
    end else if (upd && ctrl_q[tmr_pkg::CTRL_OPM]) begin
      ctrl_q[tmr_pkg::CTRL_EN] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_q <= '0;
      per_q <= tmr_pkg::PERIOD_RST;
      chm_q <= '0;
      dt_q  <= '0;
      ien_q <= '0;
      den_q <= '0;
    end else if (do_wr) begin
      case (waddr_q)
        tmr_pkg::OFF_PSC:    psc_q <= (psc_q & ~wmask[15:0]) | (wdat_q[15:0] & wmask[15:0]);
        tmr_pkg::OFF_PERIOD: per_q <= (per_q & ~wmask[15:0]) | (wdat_q[15:0] & wmask[15:0]);
        tmr_pkg::OFF_CHMODE: chm_q <= (chm_q & ~wmask[15:0]) | (wdat_q[15:0] & wmask[15:0]);
        tmr_pkg::OFF_DT:     dt_q  <= (dt_q & ~wmask[8:0]) | (wdat_q[8:0] & wmask[8:0]);
        tmr_pkg::OFF_IEN:    if (wstb_q[0]) ien_q <= wdat_q[4:0];
        tmr_pkg::OFF_DEN:    if (wstb_q[0]) den_q <= wdat_q[4:0];
        default: ;
      endcase
    end
  end

  // AXI4-Lite write channel
  assign wmask = {{8{wstb_q[3]}}, {8{wstb_q[2]}}, {8{wstb_q[1]}}, {8{wstb_q[0]}}};
  assign do_wr = aw_full_q && w_full_q && !bvalid;
  always_comb begin
    case (waddr_q)
      tmr_pkg::OFF_CTRL, tmr_pkg::OFF_PSC, tmr_pkg::OFF_PERIOD, tmr_pkg::OFF_COUNT,
      tmr_pkg::OFF_CHMODE, tmr_pkg::OFF_DT, tmr_pkg::OFF_STAT, tmr_pkg::OFF_CLR,
      tmr_pkg::OFF_IEN, tmr_pkg::OFF_DEN: wr_ok = 1'b1;
      default: wr_ok = (waddr_q >= tmr_pkg::OFF_CMP0) && (waddr_q < tmr_pkg::OFF_DT);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      waddr_q   <= '0;
      wdat_q    <= '0;
      wstb_q    <= '0;
      bvalid    <= 1'b0;
      bresp     <= tmr_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_full_q <= 1'b1;
        waddr_q   <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_full_q <= 1'b1;
        wdat_q   <= wdata;
        wstb_q   <= wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_comb begin
    rd_mux = '0;
    rd_ok  = 1'b1;
    case ({araddr[7:2], 2'b00})
      tmr_pkg::OFF_CTRL:   rd_mux[9:0]  = ctrl_q;
      tmr_pkg::OFF_PSC:    rd_mux[15:0] = psc_q;
      tmr_pkg::OFF_PERIOD: rd_mux[15:0] = per_q;
      tmr_pkg::OFF_COUNT:  rd_mux[15:0] = cnt_q;
      tmr_pkg::OFF_CHMODE: rd_mux[15:0] = chm_q;
      tmr_pkg::OFF_DT:     rd_mux[8:0]  = dt_q;
      tmr_pkg::OFF_STAT:   rd_mux[4:0]  = stat_q;
      tmr_pkg::OFF_CLR:    rd_mux       = '0;
      tmr_pkg::OFF_IEN:    rd_mux[4:0]  = ien_q;
      tmr_pkg::OFF_DEN:    rd_mux[4:0]  = den_q;
      8'h14:               rd_mux[15:0] = cmp_q[0];
      8'h18:               rd_mux[15:0] = cmp_q[1];
      8'h1C:               rd_mux[15:0] = cmp_q[2];
      8'h20:               rd_mux[15:0] = cmp_q[3];
      default:             rd_ok        = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= tmr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= rd_ok ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// [testbench/pwm_timer_properties.sv]
/*
  Concurrent checks on the timer's bus handshakes and output pins.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module pwm_timer_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Pins
  input wire logic [3:0]  ch_out,
  input wire logic [2:0]  ch_out_n,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response missing");
  a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_b_blocks: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  a_b_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not freed");
  a_rd_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response missing");
  a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_rd_err_zero: assert property (rvalid && rresp == tmr_pkg::RESP_ERR |-> rdata == 32'h0)
    else $error("error read not zero");
  a_pair_excl: assert property ((ch_out[2:0] & ch_out_n) == 3'h0)
    else $error("both pair outputs active");
  a_reset_idle: assert property ($rose(aresetn) |-> !irq && !bvalid && !rvalid && arready)
    else $error("not idle after reset");
endmodule

// [testbench/drive_model.sv]
/*
  Far-side model: quadrature encoder, hall sensors, linked timer.
  Assumes the bench calls its tasks; each step is slow enough for the sync stages.
*/
`timescale 1ns/10ps
module drive_model (
  // Clock
  input wire logic  aclk,
  // Sources
  output logic       enc_a,
  output logic       enc_b,
  output logic [2:0] hall_in,
  output logic       trig_in
);
  logic [1:0] ph = 2'h0;
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    hall_in = 3'h0;
    trig_in = 1'b0;
  end
  // Gray steps, a leads b when going forward
  task automatic enc_step(input logic fwd);
    @(posedge aclk);
    ph = fwd ? ph + 2'h1 : ph - 2'h1;
    enc_a <= ph[0] ^ ph[1];
    enc_b <= ph[1];
    repeat (4) @(posedge aclk);
  endtask
  // One sensor changes per step
  task automatic hall_step();
    @(posedge aclk);
    hall_in <= {hall_in[1:0], ~hall_in[2]};
    repeat (4) @(posedge aclk);
  endtask
  task automatic trig_pulse();
    @(posedge aclk);
    trig_in <= 1'b1;
    @(posedge aclk);
    trig_in <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
endmodule

// [testbench/pwm_timer_bench.sv]
/*
  Self-checking bench for the timer through its register bus.
  Assumes drive_model supplies encoder, hall and trigger inputs.
*/
`timescale 1ns/10ps
module pwm_timer_bench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dbg_halt;
  logic        awready, wready, bvalid, arready, rvalid, enc_a, enc_b, trig_in;
  logic        trig_out, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, r2;
  logic [3:0]  wstrb, cap_in, ch_out;
  logic [2:0]  hall_in, ch_out_n;
  logic [1:0]  bresp, rresp, rr;
  logic [4:0]  dma_req;
  int          n_errors, check_count, nt, nd, nh, n;
  int          ctl[4] = '{1, 3, 5, 1};
  int          psc[4] = '{0, 0, 0, 1};
  int          et[4] = '{12, 12, 16, 6};
  pwm_timer pwm_timer_i (.*);
  drive_model drive_model_i (.aclk, .enc_a, .enc_b, .hall_in, .trig_in);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  // Skips the output pipeline, then counts updates, update requests and ch3 high cycles
  task automatic watch(input int cycles);
    repeat (4) @(posedge aclk);
    nt = 0;
    nd = 0;
    nh = 0;
    repeat (cycles) begin
      @(posedge aclk);
      nt += int'(trig_out);
      nd += int'(dma_req[0]);
      nh += int'(ch_out[3]);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, dbg_halt} = '0;
    {awaddr, araddr, wdata, cap_in} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(tmr_pkg::OFF_PERIOD, rd, rr);
    check(rd, 32'h0000FFFF);
    rdr(8'hFC, rd, rr);
    check(32'(rr), 32'(tmr_pkg::RESP_ERR));
    wr(8'hFC, 32'h1, tmr_pkg::RESP_ERR);
    wr(tmr_pkg::OFF_PERIOD, 32'h3);
    wr(tmr_pkg::OFF_CHMODE, 32'hA000);
    wr(tmr_pkg::OFF_CMP0 + 8'h0C, 32'h2);
    wr(tmr_pkg::OFF_DEN, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(tmr_pkg::OFF_PSC, 32'(psc[i]));
      wr(tmr_pkg::OFF_CTRL, 32'(ctl[i]));
      watch(48);
      check(32'(nt), 32'(et[i]));
      check(32'(nd), 32'(et[i]));
      check(32'(nh), 32'h18);
    end
    for (int c = 0; c < 5; c += 4) begin
      wr(tmr_pkg::OFF_CMP0 + 8'h0C, 32'(c));
      watch(48);
      check(32'(nh), 32'(c * 12));
    end
    // One-pulse run, then interrupt mask and clear
    wr(tmr_pkg::OFF_CTRL, 32'h0);
    wr(tmr_pkg::OFF_CLR, 32'h1F);
    wr(tmr_pkg::OFF_IEN, 32'h1);
    check(32'(irq), 32'h0);
    wr(tmr_pkg::OFF_CTRL, 32'h9);
    repeat (10) @(posedge aclk);
    rdr(tmr_pkg::OFF_CTRL, rd, rr);
    check(rd, 32'h8);
    check(32'(irq), 32'h1);
    wr(tmr_pkg::OFF_IEN, 32'h0);
    @(posedge aclk);
    check(32'(irq), 32'h0);
    wr(tmr_pkg::OFF_IEN, 32'h1);
    @(posedge aclk);
    check(32'(irq), 32'h1);
    wr(tmr_pkg::OFF_CLR, 32'h1);
    @(posedge aclk);
    check(32'(irq), 32'h0);
    // Dead time of 2 on pair 0
    wr(tmr_pkg::OFF_PERIOD, 32'hF);
    wr(tmr_pkg::OFF_CMP0, 32'h8);
    wr(tmr_pkg::OFF_CHMODE, 32'h000A);
    wr(tmr_pkg::OFF_DT, 32'h102);
    wr(tmr_pkg::OFF_CTRL, 32'h1);
    n = 0;
    while (!ch_out[0] && n < 100) begin
      @(posedge aclk);
      n++;
    end
    while (ch_out[0] && n < 100) begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    while (!ch_out_n[0] && n < 100) begin
      @(posedge aclk);
      n++;
    end
    check(32'(n), 32'h3);
    // Debug halt freezes and forces off
    wr(tmr_pkg::OFF_CTRL, 32'h31);
    dbg_halt <= 1'b1;
    repeat (4) @(posedge aclk);
    check(32'({ch_out_n, ch_out}), 32'h0);
    rdr(tmr_pkg::OFF_COUNT, rd, rr);
    repeat (8) @(posedge aclk);
    rdr(tmr_pkg::OFF_COUNT, r2, rr);
    check(r2, rd);
    dbg_halt <= 1'b0;
    // Encoder forward then back
    wr(tmr_pkg::OFF_PERIOD, 32'hFFFF);
    wr(tmr_pkg::OFF_CTRL, 32'h41);
    wr(tmr_pkg::OFF_COUNT, 32'h100);
    repeat (8) drive_model_i.enc_step(1'b1);
    rdr(tmr_pkg::OFF_COUNT, rd, rr);
    // Prescale of two: eight steps give four counts
    check(rd, 32'h104);
    repeat (8) drive_model_i.enc_step(1'b0);
    rdr(tmr_pkg::OFF_COUNT, rd, rr);
    check(rd, 32'h100);
    // Linked timer as counting source
    wr(tmr_pkg::OFF_PSC, 32'h0);
    wr(tmr_pkg::OFF_CTRL, 32'h81);
    wr(tmr_pkg::OFF_COUNT, 32'h0);
    repeat (5) drive_model_i.trig_pulse();
    rdr(tmr_pkg::OFF_COUNT, rd, rr);
    check(rd, 32'h5);
    // Hall change and pin capture
    wr(tmr_pkg::OFF_CHMODE, 32'h0011);
    wr(tmr_pkg::OFF_CTRL, 32'h101);
    wr(tmr_pkg::OFF_CLR, 32'h1F);
    drive_model_i.hall_step();
    cap_in <= 4'h2;
    repeat (8) @(posedge aclk);
    rdr(tmr_pkg::OFF_STAT, rd, rr);
    check(32'(rd[1]), 32'h1);
    check(32'(rd[2]), 32'h1);
    wrap_up();
  end
endmodule
bind pwm_timer pwm_timer_properties pwm_timer_properties_i (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ch_out, .ch_out_n, .irq
);
